// [rtl/ipic_defs.svh]
// constants for the cross-core interrupt command block
`ifndef IPIC_DEFS_SVH
`define IPIC_DEFS_SVH
`define IPIC_VEC_LO 0
`define IPIC_DM_LO 8
`define IPIC_DSTMODE_BIT 11
`define IPIC_STATUS_BIT 12
`define IPIC_LEVEL_BIT 14
`define IPIC_TRIG_BIT 15
`define IPIC_SH_LO 18
`define IPIC_DEST_LO 56
`define IPIC_XDEST_LO 32
`define IPIC_RESET_VALUE 64'h0000000000000000
`define IPIC_BCAST8 8'hFF
`define IPIC_BCAST4 4'hF
`define IPIC_BCAST32 32'hFFFFFFFF
`endif

// [rtl/ipic_pkg.sv]
// types for the cross-core interrupt command block
`default_nettype none
package ipic_pkg;
  typedef enum logic [2:0] {
    IPIC_DM_FIXED = 3'h0,
    IPIC_DM_LOWEST = 3'h1,
    IPIC_DM_SYSMGMT = 3'h2,
    IPIC_DM_RSVD = 3'h3,
    IPIC_DM_NMI = 3'h4,
    IPIC_DM_INIT = 3'h5,
    IPIC_DM_START = 3'h6,
    IPIC_DM_RSVD7 = 3'h7
  } ipic_dm_t;
  typedef enum logic [1:0] {
    IPIC_SH_NONE = 2'h0,
    IPIC_SH_SELF = 2'h1,
    IPIC_SH_ALL_INC = 2'h2,
    IPIC_SH_ALL_EXC = 2'h3
  } ipic_sh_t;
  // one message as it travels on the system bus
  typedef struct packed {
    logic [7:0] vector;
    ipic_dm_t mode;
    logic logical;
    logic level;
    logic trigger;
    logic broadcast;
    logic excl_self;
    logic self_only;
    logic deassert;
    logic may_self;
    logic [31:0] dest;
    logic [7:0] src_id;
  } ipic_msg_t;
endpackage
`default_nettype wire

// [rtl/ipic_link_if.sv]
// link between the issuing controller and the receiving controllers
`timescale 1ns/100ps
`default_nettype none
interface ipic_link_if;
  import ipic_pkg::*;
  logic valid;        // message offered
  ipic_msg_t msg;     // message contents
  logic accept;       // targets accepted the message
  modport issuer (output valid, output msg, input accept);
  modport receiver (input valid, input msg, output accept);
endinterface
`default_nettype wire

// [rtl/ipic_issue.sv]
// issuing end: command register, encoding and dispatch
// What this block and its software do
// [RL1] all-excluding-self: physical broadcast, skip issuer
// [RL2] lowest plus exclude-self may return to issuer
// [RL3] destination used only with shorthand 00
// [RL4] physical id from bits 56-63 or 56-59
// [RL5] logical destination sent unchanged
// [RL6] low half may need reprogramming after sleep
// [RL7] newer variant forces level trigger to edge
// [RL8] software pairs self shorthands with fixed only
// [RL9] shorthand set: destination mode ignored
// [RL10] lowest exclude-self may hit issuer itself
// [RL11] older level fixed/lowest/nmi: level1 edge else drop
// [RL12] older init level0 level: deassert sync message
// [RL13] software avoids invalid older combinations
// [RL14] extended low word lacks delivery status
// [RL15] extended destination is 32-bit upper half
// [RL16] extended single full write dispatches
// [RL17] extended reads are side-effect free
// [RL18] extended all-ones destination is broadcast
// [RL19] self register path also available
// [RL20] legacy low word write sends message
// [RL21] shorthand 00 none, 01 self, 10 all
// [RL22] legacy delivery status pending until accepted
`timescale 1ns/100ps
`default_nettype none
`include "ipic_defs.svh"
module ipic_issue (
  input wire logic clk,                 // core clock
  input wire logic rst_n,               // async reset, active low
  input wire logic newer,               // 1 newer variant, 0 older
  input wire logic extended,            // extended addressing mode
  input wire logic [7:0] own_id,        // issuing controller id
  input wire logic wr_lo,               // write low word (legacy)
  input wire logic wr_hi,               // write high word (legacy)
  input wire logic wr_full,             // 64-bit write (extended)
  input wire logic self_wr,             // own-core interrupt register write
  input wire logic [63:0] wdata,        // write data
  output logic [63:0] rdata,            // command register read
  ipic_link_if.issuer link              // system bus side
);
  import ipic_pkg::*;

  typedef struct packed {
    logic [63:0] cmd;
    logic pending;
    logic valid;
    ipic_msg_t msg;
  } ipic_iss_t;

  ipic_iss_t r;
  ipic_iss_t next_r;
  // working values of the message build, rebuilt every cycle
  logic [63:0] src;
  logic fire;
  ipic_msg_t m;
  ipic_sh_t sh;
  logic lvl_trig;
  logic [31:0] bcast_dest;

  // ****************************************
  // broadcast destination per layout
  // ****************************************
  // all ones at the width of the id in use: 32 bits extended,
  // 8 bits newer, 4 bits older
  always_comb begin
    if (extended) begin
      bcast_dest = `IPIC_BCAST32; // RL18
    end else if (newer) begin
      bcast_dest = {24'h0, `IPIC_BCAST8}; // RL1
    end else begin
      bcast_dest = {28'h0, `IPIC_BCAST4}; // RL1
    end
  end

  // ****************************************
  // message build
  // ****************************************
  always_comb begin
    next_r = r;
    src = r.cmd;
    fire = 1'b0;
    m = '0;
    // legacy halves: the high write only stores
    if (wr_hi && !extended) begin
      next_r.cmd[63:32] = wdata[63:32];
    end
    // the low write stores and sends with the stored high half
    if (wr_lo && !extended) begin
      next_r.cmd[31:0] = wdata[31:0];
      src = {r.cmd[63:32], wdata[31:0]};
      fire = 1'b1; // RL20
    end
    // wide layout: one full write stores and sends at once
    if (wr_full && extended) begin
      next_r.cmd = wdata;
      src = wdata;
      fire = 1'b1; // RL16
    end
    // own-core register never touches the command register
    if (self_wr) begin
      // vector only, self shorthand, fixed, edge
      src = 64'h0;
      src[7:0] = wdata[7:0];
      src[`IPIC_SH_LO +: 2] = IPIC_SH_SELF; // RL19
      fire = 1'b1;
    end
    // decode whichever word is being sent this cycle
    sh = ipic_sh_t'(src[`IPIC_SH_LO +: 2]); // RL21
    lvl_trig = src[`IPIC_TRIG_BIT];
    m.vector = src[`IPIC_VEC_LO +: 8];
    m.mode = ipic_dm_t'(src[`IPIC_DM_LO +: 3]);
    m.src_id = own_id;
    m.level = 1'b1;
    m.trigger = 1'b0;
    // the shorthand overrides destination and its mode
    unique case (sh)
      IPIC_SH_NONE: begin
        m.logical = src[`IPIC_DSTMODE_BIT];
        if (extended) begin
          m.dest = src[`IPIC_XDEST_LO +: 32]; // RL15
          m.broadcast = (m.dest == `IPIC_BCAST32); // RL18
        end else if (newer) begin
          m.dest = {24'h0, src[`IPIC_DEST_LO +: 8]}; // RL4 RL5
          m.broadcast = !m.logical &&
            (src[`IPIC_DEST_LO +: 8] == `IPIC_BCAST8);
        end else begin
          m.dest = m.logical ? {24'h0, src[`IPIC_DEST_LO +: 8]}
                             : {28'h0, src[`IPIC_DEST_LO +: 4]}; // RL4
          m.broadcast = !m.logical &&
            (src[`IPIC_DEST_LO +: 4] == `IPIC_BCAST4);
        end
      end
      IPIC_SH_SELF: begin
        m.self_only = 1'b1; // RL3 RL9
        m.dest = {24'h0, own_id};
      end
      IPIC_SH_ALL_INC: begin
        m.broadcast = 1'b1;
        m.dest = bcast_dest;
      end
      IPIC_SH_ALL_EXC: begin
        m.broadcast = 1'b1; // RL1
        m.excl_self = 1'b1;
        m.logical = 1'b0; // RL9
        m.dest = bcast_dest;
        m.may_self = (m.mode == IPIC_DM_LOWEST); // RL2 RL10
      end
    endcase
    // trigger and level handling per variant
    if (newer || extended) begin
      m.trigger = 1'b0; // RL7
    end else if (lvl_trig) begin
      if (m.mode == IPIC_DM_INIT && !src[`IPIC_LEVEL_BIT]) begin
        // sync goes to everyone whatever the shorthand said
        m.deassert = 1'b1; // RL12
        m.broadcast = 1'b1;
        m.self_only = 1'b0;
        m.excl_self = 1'b0;
        m.may_self = 1'b0;
        m.logical = 1'b0;
        m.dest = bcast_dest;
        m.level = 1'b0;
        m.trigger = 1'b1;
      end else if (!src[`IPIC_LEVEL_BIT]) begin
        fire = 1'b0; // RL11
      end
    end
    // targets took it: drop the offer and clear the status
    if (link.accept) begin
      next_r.valid = 1'b0;
      next_r.pending = 1'b0; // RL22
    end
    if (fire) begin
      // a new send is taken even while an old one waits
      next_r.valid = 1'b1;
      next_r.pending = 1'b1;
      next_r.msg = m;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // the low half is simply kept; after deep sleep software rewrites it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{cmd: `IPIC_RESET_VALUE, default: '0};
    end else begin
      r <= next_r; // RL6
    end
  end

  // ****************************************
  // read side
  // ****************************************
  // reads only look, never dispatch
  always_comb begin
    rdata = r.cmd; // RL17
    rdata[`IPIC_STATUS_BIT] = extended ? 1'b0 : r.pending; // RL14 RL22
  end

  // ****************************************
  // system bus side
  // ****************************************
  // straight from flops, so receivers see no decode glitches
  assign link.valid = r.valid;
  assign link.msg = r.msg;
endmodule
`default_nettype wire

// [rtl/ipic_receive.sv]
// receiving end: one controller that accepts bus messages
`timescale 1ns/100ps
`default_nettype none
module ipic_receive (
  input wire logic clk,                 // core clock
  input wire logic rst_n,               // async reset, active low
  input wire logic [7:0] own_id,        // this controller id
  input wire logic [7:0] logical_id,    // logical identifier value
  ipic_link_if.receiver link,           // system bus side
  output logic hit,                     // one-cycle: message for us
  output logic [7:0] hit_vector,        // vector of last hit
  output logic [2:0] hit_mode           // delivery mode of last hit
);
  import ipic_pkg::*;

  typedef struct packed {
    logic hit;
    logic [7:0] vec;
    logic [2:0] mode;
  } ipic_rcv_t;

  ipic_rcv_t r;
  ipic_rcv_t next_r;
  logic match;

  // ****************************************
  // target match
  // ****************************************
  always_comb begin
    next_r = r;
    match = 1'b0;
    if (link.msg.self_only) begin
      match = (link.msg.src_id == own_id);
    end else if (link.msg.broadcast) begin
      match = !link.msg.excl_self || link.msg.may_self ||
              (link.msg.src_id != own_id); // RL1
    end else if (link.msg.logical) begin
      match = |(link.msg.dest[7:0] & logical_id); // RL5 flat model only
    end else begin
      match = (link.msg.dest[7:0] == own_id);
    end
    next_r.hit = link.valid && match;
    if (link.valid && match) begin
      next_r.vec = link.msg.vector;
      next_r.mode = link.msg.mode;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // accept whenever offered; no retry path
  assign link.accept = link.valid;
  assign hit = r.hit;
  assign hit_vector = r.vec;
  assign hit_mode = r.mode;
endmodule
`default_nettype wire

// [tb/ipic_monitor.sv]
// link checks for the cross-core interrupt command block
`timescale 1ns/100ps
`default_nettype none
module ipic_monitor (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic valid, // message offered
  input wire ipic_pkg::ipic_msg_t msg, // message contents
  input wire logic accept // targets accepted
);
  import ipic_pkg::*;
  // ****************************************
  // handshake timing and message encoding on the link
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  accept_tracks_a: assert property (valid |-> accept)
    else $error("message offered but not accepted");
  // receiver accepts at once, so anything longer is a stuck message
  pulse_once_a: assert property ($rose(valid) |=> !valid)
    else $error("message offered for more than one cycle");
  excl_bcast_a: assert property (valid && msg.excl_self |->
    msg.broadcast && !msg.logical && msg.dest[3:0] == 4'hF)
    else $error("exclude-self message is not a physical broadcast");
  self_lone_a: assert property (valid && msg.self_only |->
    !msg.broadcast && !msg.excl_self)
    else $error("self message also marked broadcast");
  may_self_a: assert property (valid && msg.may_self |->
    msg.mode == IPIC_DM_LOWEST && msg.excl_self)
    else $error("return to issuer outside lowest exclude-self");
  deassert_init_a: assert property (valid && msg.deassert |->
    msg.mode == IPIC_DM_INIT && !msg.level && msg.broadcast)
    else $error("deassert message with wrong fields");
  edge_only_a: assert property (valid && !msg.deassert |->
    !msg.trigger)
    else $error("level trigger left on a message");
  bcast_ones_a: assert property (valid && msg.broadcast |->
    msg.dest[3:0] == 4'hF)
    else $error("broadcast without all-ones destination");
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench joining issuing and receiving ends
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ipic_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic newer = 1'b1;
  logic extended = 1'b0;
  logic wr_lo = 1'b0;
  logic wr_hi = 1'b0;
  logic wr_full = 1'b0;
  logic self_wr = 1'b0;
  logic [63:0] wdata = 64'h0;
  logic [63:0] rdata;
  logic [7:0] rx_id = 8'h05;
  logic hit;
  logic [7:0] hit_vector;
  logic [2:0] hit_mode;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  ipic_link_if link ();
  ipic_issue u_ipic_issue (.clk(clk), .rst_n(rst_n), .newer(newer),
    .extended(extended), .own_id(8'h01), .wr_lo(wr_lo), .wr_hi(wr_hi),
    .wr_full(wr_full), .self_wr(self_wr), .wdata(wdata), .rdata(rdata),
    .link(link.issuer));
  ipic_receive u_ipic_receive (.clk(clk), .rst_n(rst_n), .own_id(rx_id),
    .logical_id(8'h10), .link(link.receiver), .hit(hit),
    .hit_vector(hit_vector), .hit_mode(hit_mode));
  ipic_monitor u_ipic_monitor (.clk(clk), .rst_n(rst_n),
    .valid(link.valid), .msg(link.msg), .accept(link.accept));
  // ****************************************
  // shared helpers
  // ****************************************
  task automatic chk(input logic ok, input string m);
    checks++;
    if (!ok) begin
      err_total++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  // flag arguments are plain numbers; only bit 0 is used
  function automatic logic [63:0] cmd(logic [7:0] v, logic [2:0] dm,
    int lg, int lv, int tr, logic [1:0] sh, logic [7:0] d);
    cmd = {d, 36'h0, sh, 2'b00, tr[0], lv[0], 2'b00, lg[0], dm, v};
  endfunction
  // legacy writes the high half first so the low write fires with it
  task automatic shot(input logic [63:0] d, input int ex);
    logic seen;
    seen = 1'b0;
    wdata = d;
    if (extended) wr_full = 1'b1;
    else wr_hi = 1'b1;
    @(posedge clk); #1;
    wr_hi = 1'b0;
    wr_full = 1'b0;
    if (!extended) begin
      wr_lo = 1'b1;
      @(posedge clk); #1;
      wr_lo = 1'b0;
      if (ex) chk(rdata[12] === 1'b1, "status not pending");
    end
    repeat (3) begin
      @(posedge clk); #1;
      if (hit === 1'b1) seen = 1'b1;
    end
    chk(seen === ex[0], "delivery differs");
    if (ex) chk(hit_vector === d[7:0], "wrong vector");
    if (ex) chk(hit_mode === d[10:8], "wrong delivery mode");
    chk(rdata[12] === 1'b0, "status stuck");
    chk(rdata === d, "command readback differs");
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_phys();
    shot(cmd(8'h41, IPIC_DM_FIXED, 0, 1, 0, 2'h0, 8'h05), 1);
    shot(cmd(8'h42, IPIC_DM_FIXED, 0, 1, 0, 2'h0, 8'h06), 0);
    shot(cmd(8'h43, IPIC_DM_FIXED, 0, 1, 0, 2'h2, 8'h06), 1);
    shot(cmd(8'h44, IPIC_DM_FIXED, 1, 1, 0, 2'h0, 8'h10), 1);
    shot(cmd(8'h45, IPIC_DM_FIXED, 0, 1, 1, 2'h0, 8'h05), 1);
  endtask
  task automatic t_short();
    rx_id = 8'h01;
    shot(cmd(8'h51, IPIC_DM_FIXED, 0, 1, 0, 2'h3, 8'h01), 0);
    shot(cmd(8'h52, IPIC_DM_FIXED, 1, 1, 0, 2'h1, 8'h06), 1);
    rx_id = 8'h05;
    shot(cmd(8'h53, IPIC_DM_LOWEST, 0, 1, 0, 2'h3, 8'h00), 1);
    shot(cmd(8'h54, IPIC_DM_FIXED, 1, 1, 0, 2'h3, 8'h00), 1);
  endtask
  // older variant: only the low nibble names a physical target
  task automatic t_old();
    newer = 1'b0;
    shot(cmd(8'h61, IPIC_DM_FIXED, 0, 1, 0, 2'h0, 8'h35), 1);
    shot(cmd(8'h62, IPIC_DM_FIXED, 0, 0, 1, 2'h0, 8'h05), 0);
    shot(cmd(8'h63, IPIC_DM_NMI, 0, 1, 1, 2'h0, 8'h05), 1);
    shot(cmd(8'h00, IPIC_DM_INIT, 0, 0, 1, 2'h2, 8'h09), 1);
    newer = 1'b1;
  endtask
  // own-core register: vector only, lands on the issuer
  task automatic t_self();
    logic [63:0] keep;
    logic seen;
    keep = rdata;
    seen = 1'b0;
    rx_id = 8'h01;
    wdata = 64'h0000000000000081;
    self_wr = 1'b1;
    @(posedge clk); #1;
    self_wr = 1'b0;
    repeat (3) begin
      @(posedge clk); #1;
      if (hit === 1'b1) seen = 1'b1;
    end
    chk(seen === 1'b1, "self write not delivered");
    chk(hit_vector === 8'h81, "self vector wrong");
    chk(hit_mode === IPIC_DM_FIXED, "self mode not fixed");
    chk(rdata === keep, "self write changed command");
    rx_id = 8'h05;
  endtask
  task automatic t_ext();
    logic [63:0] c;
    logic [63:0] keep;
    logic seen;
    extended = 1'b1;
    c = cmd(8'h71, IPIC_DM_FIXED, 0, 1, 0, 2'h0, 8'h00);
    shot({32'h00000005, c[31:0]}, 1);
    chk(rdata === {32'h00000005, c[31:0]}, "readback");
    // half writes are refused while the wide layout is on
    keep = rdata;
    seen = 1'b0;
    wdata = {32'h00000005, c[31:8], 8'h72};
    wr_lo = 1'b1;
    wr_hi = 1'b1;
    @(posedge clk); #1;
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    repeat (3) begin
      @(posedge clk); #1;
      if (hit === 1'b1) seen = 1'b1;
    end
    chk(seen === 1'b0, "half write sent in wide layout");
    chk(rdata === keep, "half write stored in wide layout");
    rx_id = 8'h07;
    shot({32'hFFFFFFFF, c[31:0]}, 1);
    extended = 1'b0;
  endtask
  task automatic end_sim();
    if (err_total == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // clock, watchdog and sequence
  // ****************************************
  initial begin
    forever #5 clk = ~clk;
  end
  // a run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_phys();
    t_short();
    t_self();
    t_old();
    t_ext();
    end_sim();
  end
endmodule
`default_nettype wire
